// ### dv/mem_model.sv
// behavioural external memory on the cache's word bus
// assumes mem_addr, mem_we and mem_wdata stand until mem_ack
`timescale 1ns/100ps
module mem_model
(
  input wire logic aclk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic slow,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic [31:0] rd_words,
  output logic [31:0] wr_words
);
  // ==========================================
  // storage and stall state
  logic [31:0] store [logic [31:0]]; // sparse words, unwritten read as ~addr
  logic [1:0] wait_r; // stall cycles spent on this word
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    rd_words = 32'h0;
    wr_words = 32'h0;
    wait_r = 2'h0;
  end
  // ==========================================
  // one word per ack, slow mode stalls two cycles
  always @(posedge aclk)
  begin
    if (mem_ack)
    begin
      mem_ack <= 1'b0;
      // released data bus must not keep the last word
      mem_rdata <= ~mem_rdata;
      if (mem_we)
      begin
        store[mem_addr] = mem_wdata;
        wr_words <= wr_words + 32'h1;
      end
      else
        rd_words <= rd_words + 32'h1;
    end
    else if (mem_req && wait_r < (slow ? 2'h2 : 2'h0))
      wait_r <= wait_r + 2'h1;
    else if (mem_req)
    begin
      wait_r <= 2'h0;
      mem_ack <= 1'b1;
      mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : ~mem_addr;
    end
  end
endmodule : mem_model

// ### dv/test_unified_four_way_cache_control.sv
// self-checking bench: register bus tasks, cpu accesses, word counts at memory
// assumes cache_top and mem_model share one 10 MHz clock
`timescale 1ns/100ps
module test_unified_four_way_cache_control;
  import cache_pkg::*;
  // ==========================================
  // signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cpu_ack, mem_req, mem_we, mem_ack;
  logic cpu_req, cpu_we, slow;
  logic [31:0] awaddr, wdata, araddr, rdata, cpu_addr, cpu_wdata, cpu_rdata;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, rd_words, wr_words;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int num_errors = 0;
  int compares = 0;
  always #50 aclk = ~aclk;
  cache_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  mem_model far_mem (.aclk(aclk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .rd_words(rd_words), .wr_words(wr_words));
  // ==========================================
  // reporting
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tmo();
    num_errors++;
    $display("CHECK FAILED t=%0t no answer", $time);
    end_sim();
  endtask : tmo
  // ==========================================
  // register bus, both channels offered together
  // control writes come from their own master, never from cached code
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awready === 1'b1 && awvalid) awvalid <= 1'b0;
      if (wready === 1'b1 && wvalid) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 50) tmo();
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask : wr_reg
  task automatic rd_reg(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arready === 1'b1 && arvalid) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 50) tmo();
    rready <= 1'b0;
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
  endtask : rd_reg
  // ==========================================
  // one cpu word access, then memory words read and written during it
  task automatic acc(input logic we, input logic [31:0] a, input logic [31:0] wd,
                     input logic [31:0] erd, input logic [31:0] nr, input logic [31:0] nw);
    logic [31:0] r0, w0;
    int n;
    @(posedge aclk);
    r0 = rd_words;
    w0 = wr_words;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= wd;
    cpu_req <= 1'b1;
    for (n = 0; n < 300; n++)
    begin
      @(posedge aclk);
      if (cpu_ack === 1'b1) break;
    end
    if (n == 300) tmo();
    cpu_req <= 1'b0;
    if (!we) check(cpu_rdata, erd);
    check(rd_words - r0, nr);
    check(wr_words - w0, nw);
  endtask : acc
  // ==========================================
  // main sequence
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_req, cpu_we, slow} = 10'h0;
    {awaddr, wdata, araddr, cpu_addr, cpu_wdata} = 160'h0;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(CTRL_ADDR, 32'h0, RESP_OKAY);
    rd_reg(CTRL_ADDR + 32'h4, 32'h0, RESP_SLVERR);
    // strobe-less and unmapped writes leave the cache off
    wstrb <= 4'h0;
    wr_reg(CTRL_ADDR, 32'h0000_0001, RESP_OKAY);
    wstrb <= 4'hF;
    wr_reg(CTRL_ADDR + 32'h8, 32'h0000_0001, RESP_SLVERR);
    rd_reg(CTRL_ADDR, 32'h0, RESP_OKAY);
    // cache off: every word goes out
    acc(1'b0, 32'h0000_0100, 32'h0, ~32'h0000_0100, 32'h1, 32'h0);
    acc(1'b1, 32'h0000_0104, 32'hA5A5_0001, 32'h0, 32'h0, 32'h1);
    // set every control bit, flush reads back zero
    wr_reg(CTRL_ADDR, 32'h0000_000F, RESP_OKAY);
    rd_reg(CTRL_ADDR, 32'h0000_0007, RESP_OKAY);
    wr_reg(CTRL_ADDR, 32'h0000_0001, RESP_OKAY);
    // whole-line fill, then hits in the same line and via shadow bits
    acc(1'b0, 32'h0000_0100, 32'h0, ~32'h0000_0100, 32'h4, 32'h0);
    acc(1'b0, 32'h0000_0104, 32'h0, 32'hA5A5_0001, 32'h0, 32'h0);
    acc(1'b0, 32'h2000_0108, 32'h0, ~32'h0000_0108, 32'h0, 32'h0);
    // another tag in the same set fills a second way
    acc(1'b0, 32'h0000_1100, 32'h0, ~32'h0000_1100, 32'h4, 32'h0);
    acc(1'b0, 32'h0000_0100, 32'h0, ~32'h0000_0100, 32'h0, 32'h0);
    // write-back hit stays inside the cache
    acc(1'b1, 32'h0000_010C, 32'h1234_5678, 32'h0, 32'h0, 32'h0);
    acc(1'b0, 32'h0000_010C, 32'h0, 32'h1234_5678, 32'h0, 32'h0);
    // flush drops the dirty line without writing it out
    wr_reg(CTRL_ADDR, 32'h0000_0009, RESP_OKAY);
    acc(1'b0, 32'h0000_010C, 32'h0, ~32'h0000_010C, 32'h4, 32'h0);
    // dirty line, then three misses walk the order to it: way 2, way 1, way 0
    acc(1'b1, 32'h0000_0100, 32'h5A5A_0007, 32'h0, 32'h0, 32'h0);
    acc(1'b0, 32'h0000_1100, 32'h0, ~32'h0000_1100, 32'h4, 32'h0);
    acc(1'b0, 32'h0000_2100, 32'h0, ~32'h0000_2100, 32'h4, 32'h0);
    acc(1'b0, 32'h0000_3100, 32'h0, ~32'h0000_3100, 32'h4, 32'h0);
    // way 3 is oldest again: its dirty line goes out before the refill
    acc(1'b0, 32'h0000_4100, 32'h0, ~32'h0000_4100, 32'h4, 32'h4);
    // write-through for region 0
    wr_reg(CTRL_ADDR, 32'h0000_0003, RESP_OKAY);
    acc(1'b1, 32'h0000_0200, 32'hCAFE_0003, 32'h0, 32'h0, 32'h1);
    acc(1'b0, 32'h0000_0200, 32'h0, 32'hCAFE_0003, 32'h4, 32'h0);
    acc(1'b1, 32'h0000_0200, 32'hCAFE_0004, 32'h0, 32'h0, 32'h1);
    acc(1'b0, 32'h0000_0200, 32'h0, 32'hCAFE_0004, 32'h0, 32'h0);
    // region 1 with a slow memory: through, then back
    slow <= 1'b1;
    acc(1'b0, 32'h8000_0300, 32'h0, ~32'h8000_0300, 32'h4, 32'h0);
    acc(1'b1, 32'h8000_0300, 32'hBEEF_0005, 32'h0, 32'h0, 32'h1);
    wr_reg(CTRL_ADDR, 32'h0000_0007, RESP_OKAY);
    acc(1'b1, 32'h8000_0300, 32'hBEEF_0006, 32'h0, 32'h0, 32'h0);
    // uncached and io regions never fill
    acc(1'b0, 32'hA000_0400, 32'h0, ~32'hA000_0400, 32'h1, 32'h0);
    acc(1'b0, 32'hA000_0400, 32'h0, ~32'hA000_0400, 32'h1, 32'h0);
    acc(1'b0, 32'hE000_0400, 32'h0, ~32'hE000_0400, 32'h1, 32'h0);
    // turned off again: cached line is bypassed
    slow <= 1'b0;
    wr_reg(CTRL_ADDR, 32'h0000_0000, RESP_OKAY);
    acc(1'b0, 32'h0000_0200, 32'h0, 32'hCAFE_0004, 32'h1, 32'h0);
    // the evicted dirty word reached memory
    acc(1'b0, 32'h0000_0100, 32'h0, 32'h5A5A_0007, 32'h1, 32'h0);
    end_sim();
  end
endmodule : test_unified_four_way_cache_control

// ### rtl/cache_top.sv
// unified four-way cache with axi4-lite control register
// assumes cpu holds cpu_req until cpu_ack, memory answers on the same clock
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module cache_top
  import cache_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // cpu side
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ack,
  output logic [31:0] cpu_rdata,
  // external memory side
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  // ==========================================
  // storage
  logic [31:0] data_mem [WAYS*SETS*LINE_WORDS]; // no reset
  logic [TAG_W-1:0] tag_mem [WAYS*SETS]; // no reset
  logic [WAYS*SETS-1:0] valid_r; // per entry valid
  logic [WAYS*SETS-1:0] dirty_r; // per entry dirty
  logic [5:0] lru_mem [SETS]; // per set order bits
  // ==========================================
  // control and request state
  state_t state_r; // sequencer
  logic [2:0] ctrl_r; // back, through, enable
  logic flush_pend_r; // flush waits for idle
  logic we_r; // latched direction
  logic [31:0] addr_r; // latched address
  logic [31:0] wdat_r; // latched write data
  logic [1:0] way_r; // way being refilled
  logic [1:0] cnt_r; // word counter of a line
  logic [31:0] aw_addr_r; // taken write address
  logic [31:0] w_data_r; // taken write data
  logic [3:0] w_strb_r; // taken strobes
  // ==========================================
  // request decode
  logic [7:0] idx; // set index
  logic [1:0] wrd; // word in line
  logic [TAG_W-1:0] tag_of; // tag of the request
  logic [2:0] region; // address region
  logic cacheable; // may use arrays
  logic wb_mode; // write-back policy for region
  logic hit; // lookup hit
  logic [1:0] hit_way; // way that hit
  logic [1:0] victim; // way to replace
  logic [5:0] lru_cur; // order bits of set
  logic look; // lookup cycle
  logic look_hit; // cacheable hit
  logic hit_wr; // write into a hit line
  logic fill_ack; // fill word arrives
  logic fill_last; // last fill word
  logic flush_go; // flush applied now
  logic vic_dirty; // victim needs write-back
  logic wr_go; // register write performed

  assign idx = addr_r[11:4];
  assign wrd = addr_r[3:2];
  // shadow bits never reach the tag
  assign tag_of = {{SHADOW_W{1'b0}}, addr_r[31-SHADOW_W:10]};
  assign region = addr_r[31:29];
  assign cacheable = ctrl_r[CE_BIT] && region != RGN_UNCACHED && region != RGN_IO;
  assign wb_mode = (region == RGN_SECOND) ? ctrl_r[BACK_BIT] : !ctrl_r[THRU_BIT];
  assign lru_cur = lru_mem[idx];
  assign look = state_r == ST_LOOK;
  assign look_hit = look && cacheable && hit;
  assign hit_wr = look_hit && we_r;
  assign fill_ack = state_r == ST_FILL && mem_ack;
  assign fill_last = fill_ack && cnt_r == 2'h3;
  assign flush_go = state_r == ST_IDLE && flush_pend_r;
  assign vic_dirty = valid_r[{victim, idx}] && dirty_r[{victim, idx}];
  assign wr_go = !awready && !wready && !bvalid;

  // tag compare across all ways of the set
  always_comb
  begin
    hit = 1'b0;
    hit_way = 2'h0;
    for (int w = 0; w < WAYS; w++)
    begin
      if (valid_r[{2'(w), idx}] && tag_mem[{2'(w), idx}] == tag_of)
      begin
        hit = 1'b1;
        hit_way = 2'(w);
      end
    end
  end

  // victim from pairwise order; codes with no way older than all others fall to way 3
  always_comb
  begin
    if (lru_cur[5] && lru_cur[4] && lru_cur[3])
      victim = 2'h0;
    else if (!lru_cur[5] && lru_cur[2] && lru_cur[1])
      victim = 2'h1;
    else if (!lru_cur[4] && !lru_cur[2] && lru_cur[0])
      victim = 2'h2;
    else
      victim = 2'h3;
  end

  // mark a way as most recent among the pair bits
  function automatic logic [5:0] lru_touch(input logic [5:0] old, input logic [1:0] way);
    logic [5:0] n;
    n = old;
    unique case (way)
      2'h0: n[5:3] = 3'b000;
      2'h1:
      begin
        n[5] = 1'b1;
        n[2:1] = 2'b00;
      end
      2'h2:
      begin
        n[4] = 1'b1;
        n[2] = 1'b1;
        n[0] = 1'b0;
      end
      2'h3:
      begin
        n[3] = 1'b1;
        n[1:0] = 2'b11;
      end
    endcase
    return n;
  endfunction : lru_touch

  // ==========================================
  // data and tag arrays, never reset
  always_ff @(posedge aclk)
  begin
    if (hit_wr)
      data_mem[{hit_way, idx, wrd}] <= wdat_r;
    // whole line written word by word before it turns valid
    if (fill_ack)
      data_mem[{way_r, idx, cnt_r}] <= mem_rdata;
    if (fill_last)
      tag_mem[{way_r, idx}] <= tag_of;
  end

  // ==========================================
  // flags and replacement bits
  always_ff @(posedge aclk)
  begin
    // flush drops dirty lines without writing them out
    if (!aresetn || flush_go)
    begin
      valid_r <= '0;
      dirty_r <= '0;
      for (int s = 0; s < SETS; s++)
        lru_mem[s] <= LRU_RST;
    end
    else
    begin
      if (fill_last)
      begin
        valid_r[{way_r, idx}] <= 1'b1;
        dirty_r[{way_r, idx}] <= 1'b0;
      end
      if (hit_wr && wb_mode)
        dirty_r[{hit_way, idx}] <= 1'b1;
      // refilled lines are touched by the retried lookup
      if (look_hit)
        lru_mem[idx] <= lru_touch(lru_cur, hit_way);
    end
  end

  // ==========================================
  // sequencer, cpu answer and memory requests
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_IDLE;
      cpu_ack <= 1'b0;
      cpu_rdata <= 32'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 32'h0;
      we_r <= 1'b0;
      addr_r <= 32'h0;
      wdat_r <= 32'h0;
      way_r <= 2'h0;
      cnt_r <= 2'h0;
    end
    else
    begin
      cpu_ack <= 1'b0;
      unique case (state_r)
        ST_IDLE:
        begin
          // a held request is not retaken in its ack cycle
          if (cpu_req && !cpu_ack && !flush_pend_r)
          begin
            we_r <= cpu_we;
            addr_r <= cpu_addr;
            wdat_r <= cpu_wdata;
            state_r <= ST_LOOK;
          end
        end
        ST_LOOK:
        begin
          // uncached, disabled, write-through hit or write-through miss
          if (!cacheable || (we_r && !wb_mode))
          begin
            mem_req <= 1'b1;
            mem_we <= we_r;
            mem_addr <= addr_r;
            mem_wdata <= wdat_r;
            state_r <= ST_BYP;
          end
          else if (hit)
          begin
            cpu_ack <= 1'b1;
            cpu_rdata <= data_mem[{hit_way, idx, wrd}];
            state_r <= ST_IDLE;
          end
          else
          begin
            way_r <= victim;
            cnt_r <= 2'h0;
            mem_req <= 1'b1;
            if (vic_dirty)
            begin
              // simple order: write the victim out before refilling
              mem_we <= 1'b1;
              mem_addr <= {tag_mem[{victim, idx}], idx[5:0], 4'h0};
              mem_wdata <= data_mem[{victim, idx, 2'h0}];
              state_r <= ST_WBACK;
            end
            else
            begin
              mem_we <= 1'b0;
              mem_addr <= {addr_r[31:4], 4'h0};
              state_r <= ST_FILL;
            end
          end
        end
        ST_WBACK:
        begin
          if (mem_ack)
          begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == 2'h3)
            begin
              mem_we <= 1'b0;
              mem_addr <= {addr_r[31:4], 4'h0};
              state_r <= ST_FILL;
            end
            else
            begin
              mem_addr[3:2] <= cnt_r + 2'h1;
              mem_wdata <= data_mem[{way_r, idx, cnt_r + 2'h1}];
            end
          end
        end
        ST_FILL:
        begin
          if (mem_ack)
          begin
            cnt_r <= cnt_r + 2'h1;
            mem_addr[3:2] <= cnt_r + 2'h1;
            if (cnt_r == 2'h3)
            begin
              mem_req <= 1'b0;
              state_r <= ST_LOOK;
            end
          end
        end
        ST_BYP:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            cpu_ack <= 1'b1;
            if (!we_r)
              cpu_rdata <= mem_rdata;
            state_r <= ST_IDLE;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // axi4-lite control register slave
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
      ctrl_r <= CTRL_RST;
      flush_pend_r <= 1'b0;
      aw_addr_r <= 32'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_addr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready <= 1'b0;
      end
      // a new flush request wins over the one being applied
      if (flush_go)
        flush_pend_r <= 1'b0;
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp <= (aw_addr_r == CTRL_ADDR) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr_r == CTRL_ADDR && w_strb_r[0])
        begin
          ctrl_r <= {w_data_r[BACK_BIT], w_data_r[THRU_BIT], w_data_r[CE_BIT]};
          if (w_data_r[FLUSH_BIT])
            flush_pend_r <= 1'b1;
        end
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        // flush and upper bits always read zero
        rdata <= (araddr == CTRL_ADDR) ? {29'h0, ctrl_r} : 32'h0;
        rresp <= (araddr == CTRL_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ==========================================
  // assertions
  default clocking asrt_clk @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence fill_end_s;
    fill_last;
  endsequence
  sequence line_valid_s;
    look && valid_r[{way_r, idx}];
  endsequence
  sequence wt_miss_s;
    look && cacheable && we_r && !wb_mode && !hit;
  endsequence

  AST_FILL_THEN_VALID: assert property (fill_end_s |=> line_valid_s)
    else $error("filled line not valid at retry");
  AST_WT_MISS_BYPASS: assert property (wt_miss_s |=> state_r == ST_BYP && mem_we && !hit_wr)
    else $error("write-through miss touched cache");
  AST_WB_HIT_LOCAL: assert property (look_hit && we_r && wb_mode |=> cpu_ack && !mem_req)
    else $error("write-back hit went to memory");
  AST_UNCACHED: assert property (look && (region == RGN_UNCACHED || region == RGN_IO) |=> state_r == ST_BYP)
    else $error("uncached region used arrays");
  AST_DISABLED: assert property (look && !ctrl_r[CE_BIT] |=> state_r == ST_BYP && mem_req)
    else $error("disabled cache used arrays");
  AST_FLUSH: assert property (flush_go |=> valid_r == '0 && dirty_r == '0 && !mem_req)
    else $error("flush left flags set");
  AST_RD_ZERO: assert property (rvalid |-> rdata[31:3] == 29'h0)
    else $error("reserved bits read nonzero");
  AST_HIT_VALID: assert property (look_hit |-> valid_r[{hit_way, idx}] && tag_mem[{hit_way, idx}][21:19] == '0)
    else $error("hit on invalid entry");
  AST_VICTIM0: assert property (look && !hit && cacheable && lru_cur[5:3] == 3'b111 && !we_r
    |=> way_r == 2'h0)
    else $error("wrong victim");
endmodule : cache_top

// ### shared/cache_pkg.sv
// constants and types of the unified four-way cache
// assumes one clock domain and a synchronous active-low reset
package cache_pkg;
  // ==========================================
  // geometry
  localparam int WAYS = 4; // ways per set
  localparam int SETS = 256; // entries per way
  localparam int LINE_WORDS = 4; // 4-byte words per line
  localparam int TAG_W = 22; // tag from address 31..10
  localparam int SHADOW_W = 3; // top tag bits held at zero
  // ==========================================
  // control register
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0000; // only mapped word
  localparam int CE_BIT = 0; // cache enable
  localparam int THRU_BIT = 1; // write-through for regions 0 and 3
  localparam int BACK_BIT = 2; // write-back for region 1
  localparam int FLUSH_BIT = 3; // flush all, reads zero
  localparam logic [2:0] CTRL_RST = 3'h0; // cache off, policies zero
  localparam logic [5:0] LRU_RST = 6'h00; // replacement bits after reset
  // ==========================================
  // address regions by address bits 31..29
  localparam logic [2:0] RGN_SECOND = 3'h4; // second cached region
  localparam logic [2:0] RGN_UNCACHED = 3'h5; // uncached region
  localparam logic [2:0] RGN_THIRD = 3'h6; // third cached region
  localparam logic [2:0] RGN_IO = 3'h7; // internal io region
  // ==========================================
  // bus answers and states
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_WBACK = 3'b010,
    ST_FILL = 3'b011,
    ST_BYP = 3'b100
  } state_t;
endpackage : cache_pkg
